// [pkg/sop_defines.svh]
// constants for the sum-of-products logic array: sizes, term map, config addresses
`ifndef SOP_DEFINES_SVH
`define SOP_DEFINES_SVH

`define SOP_N_IN       12
`define SOP_N_CELL     10
`define SOP_N_LINE     44
`define SOP_N_TERM     132
`define SOP_N_SUMTERM  120
`define SOP_GRP_MIN    8
`define SOP_GRP_STEP   2
`define SOP_GRP_MAX    16
// product term slots in the array
`define SOP_PT_CLEAR   0
`define SOP_PT_SUM0    1
`define SOP_PT_OE0     121
`define SOP_PT_PRESET  131
// configuration port: rows 0..131 are terms, then cell config and erase
`define SOP_ADDR_W     8
`define SOP_ADDR_MCFG  8'h84
`define SOP_ADDR_ERASE 8'h85
// cell config bit positions inside one cell's pair
`define SOP_MC_POL     0
`define SOP_MC_FBSEL   1
`define SOP_MC_W       2
// reset / erased values
`define SOP_Q_RST      1'h0
`define SOP_CELL_ERASE 1'h0

`endif

// [pkg/sop_pkg.sv]
// types and term-group helpers for the sum-of-products logic array
`include "sop_defines.svh"
package sop_pkg;

   typedef logic [`SOP_N_LINE-1:0] sop_row_type;
   typedef logic [`SOP_MC_W-1:0]   sop_mcfg_type;

   // terms in cell c's group: 8,10,12,14,16,16,14,12,10,8
   function automatic int sop_grp_size(input int c);
      int k;
      k = (c < `SOP_N_CELL/2) ? c : (`SOP_N_CELL - 1 - c);
      return `SOP_GRP_MIN + `SOP_GRP_STEP * k;
   endfunction : sop_grp_size

   // first term slot of cell c's group
   function automatic int sop_grp_base(input int c);
      int b;
      b = `SOP_PT_SUM0;
      for (int i = 0; i < c; i++) begin
         b = b + sop_grp_size(i);
      end
      return b;
   endfunction : sop_grp_base

endpackage : sop_pkg

// [design/sop_product_term.sv]
// one product term: AND of all connected array lines
`timescale 1ns/1ps
module sop_product_term (
   // crossing cells and array lines
   input  wire sop_pkg::sop_row_type cells,
   input  wire sop_pkg::sop_row_type lines,
   // term result
   output logic                      term
);

   // a disconnected crossing passes a 1, so an empty term is true and a
   // term holding both polarities of one signal is false
   assign term = &(~cells | lines);

endmodule : sop_product_term

// [design/sop_logic_array.sv]
// sum-of-products logic array: config cells, AND array, OR sums and ten output cells
`timescale 1ns/1ps
`include "sop_defines.svh"
module sop_logic_array (
   // clock doubles as input line 0, synchronous reset
   input  wire logic                        clk,
   input  wire logic                        srst,
   // dedicated input pins 1..11
   input  wire logic [`SOP_N_IN-2:0]        dedicated_inputs,
   // cell pins: level seen on the wire, value driven, driver enable
   input  wire logic [`SOP_N_CELL-1:0]      cell_io_pins_in,
   output logic      [`SOP_N_CELL-1:0]      cell_io_pins_out,
   output logic      [`SOP_N_CELL-1:0]      cell_io_pins_oe,
   // configuration port used by the programmer
   input  wire logic [`SOP_ADDR_W-1:0]      cfg_addr,
   input  wire logic [`SOP_N_LINE-1:0]      cfg_wdata,
   input  wire logic                        cfg_wr,
   input  wire logic                        cfg_rd,
   output logic      [`SOP_N_LINE-1:0]      cfg_rdata
);

   // nonvolatile crossing cells and cell configuration
   sop_pkg::sop_row_type  cell_mem [`SOP_N_TERM];
   sop_pkg::sop_mcfg_type mcfg_ff  [`SOP_N_CELL];

   logic [`SOP_N_IN-1:0]     in_pins;
   sop_pkg::sop_row_type     array_lines;
   logic [`SOP_N_TERM-1:0]   pt;
   logic [`SOP_N_CELL-1:0]   sum;
   logic [`SOP_N_CELL-1:0]   q_ff;
   logic [`SOP_N_CELL-1:0]   nxt_q;
   logic [`SOP_N_CELL-1:0]   fb;
   logic [`SOP_N_CELL-1:0]   fbsel;
   logic [`SOP_N_CELL-1:0]   pol;
   logic [`SOP_N_CELL-1:0]   cell_val;
   logic [2*`SOP_N_CELL-1:0] mcfg_flat;
   logic [`SOP_N_LINE-1:0]   nxt_rdata;
   logic [`SOP_N_LINE-1:0]   rdata_ff;
   logic                     clear_term;
   logic                     preset_term;
   logic                     wr_row;
   logic                     wr_mcfg;
   logic                     wr_erase;
   logic                     rd_row;
   logic                     rd_mcfg;

   // configuration port decode
   assign wr_row   = cfg_wr && (cfg_addr < `SOP_ADDR_MCFG);
   assign wr_mcfg  = cfg_wr && (cfg_addr == `SOP_ADDR_MCFG);
   assign wr_erase = cfg_wr && (cfg_addr == `SOP_ADDR_ERASE);
   assign rd_row   = cfg_rd && (cfg_addr < `SOP_ADDR_MCFG);
   assign rd_mcfg  = cfg_rd && (cfg_addr == `SOP_ADDR_MCFG);

   // crossing cells keep their pattern through reset; erase opens all at once
   always_ff @(posedge clk) begin
      for (int r = 0; r < `SOP_N_TERM; r++) begin
         if (wr_erase) begin
            cell_mem[r] <= '0;
         end else if (wr_row && (cfg_addr == r[`SOP_ADDR_W-1:0])) begin
            cell_mem[r] <= cfg_wdata;
         end
      end
   end

   // cell configuration pairs, erased to registered and active low
   genvar g;
   generate
      for (g = 0; g < `SOP_N_CELL; g++) begin : g_mcfg
         always_ff @(posedge clk) begin
            if (wr_erase) begin
               mcfg_ff[g] <= {`SOP_MC_W{`SOP_CELL_ERASE}};
            end else if (wr_mcfg) begin
               mcfg_ff[g] <= cfg_wdata[`SOP_MC_W*g +: `SOP_MC_W];
            end
         end
         assign mcfg_flat[`SOP_MC_W*g +: `SOP_MC_W] = mcfg_ff[g];
         assign pol[g]   = mcfg_ff[g][`SOP_MC_POL];
         assign fbsel[g] = mcfg_ff[g][`SOP_MC_FBSEL];
      end
   endgenerate

   // read data stands in the cycle after the read strobe only
   assign nxt_rdata = rd_row  ? cell_mem[cfg_addr] :
                      rd_mcfg ? {{(`SOP_N_LINE-2*`SOP_N_CELL){1'b0}}, mcfg_flat} :
                      '0;
   always_ff @(posedge clk) begin
      if (srst) begin
         rdata_ff <= '0;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end
   assign cfg_rdata = rdata_ff;

   // the clock pin is also logic input 0
   assign in_pins = {dedicated_inputs, clk};

   // true and complement lines for inputs and cell feedback
   generate
      for (g = 0; g < `SOP_N_IN; g++) begin : g_in_lines
         assign array_lines[2*g]   = in_pins[g];
         assign array_lines[2*g+1] = ~in_pins[g];
      end
      for (g = 0; g < `SOP_N_CELL; g++) begin : g_fb_lines
         assign fb[g] = fbsel[g] ? cell_io_pins_in[g] : ~q_ff[g];
         assign array_lines[2*`SOP_N_IN+2*g]   = fb[g];
         assign array_lines[2*`SOP_N_IN+2*g+1] = ~fb[g];
      end
   endgenerate

   // the AND array: one term per row of crossing cells
   generate
      for (g = 0; g < `SOP_N_TERM; g++) begin : g_terms
         sop_product_term u_term (
            .cells (cell_mem[g]),
            .lines (array_lines),
            .term  (pt[g])
         );
      end
   endgenerate

   assign clear_term  = pt[`SOP_PT_CLEAR];
   assign preset_term = pt[`SOP_PT_PRESET];

   // fixed OR of each cell's own term group
   generate
      for (g = 0; g < `SOP_N_CELL; g++) begin : g_sums
         localparam int BASE = sop_pkg::sop_grp_base(g);
         localparam int SIZE = sop_pkg::sop_grp_size(g);
         assign sum[g] = |pt[BASE +: SIZE];
      end
   endgenerate

   // preset and sum enter at the edge; clear overrides them at once, without an edge
   assign nxt_q = preset_term ? {`SOP_N_CELL{1'b1}} : sum;

   // output flip-flops: clear acts at once and wins over preset
   always_ff @(posedge clk or posedge clear_term) begin
      if (clear_term) begin
         q_ff <= {`SOP_N_CELL{`SOP_Q_RST}};
      end else if (srst) begin
         q_ff <= {`SOP_N_CELL{`SOP_Q_RST}};
      end else begin
         q_ff <= nxt_q;
      end
   end

   // output path: registered or combinational, then polarity
   // the output source is chosen bit by bit: a vector select would act on all cells at once
   assign cell_val         = (~fbsel & q_ff) | (fbsel & sum);
   assign cell_io_pins_out = cell_val ^ ~pol;
   assign cell_io_pins_oe  = pt[`SOP_PT_OE0 +: `SOP_N_CELL];

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   logic erase_seen_ff;
   always_ff @(posedge clk) begin
      if (srst) begin
         erase_seen_ff <= 1'b0;
      end else begin
         erase_seen_ff <= wr_erase;
      end
   end

   chk_preset_sets: assert property (
      preset_term && !clear_term |=> clear_term || (q_ff == {`SOP_N_CELL{1'b1}}))
      else $error("preset term did not set the flip-flops");

   chk_clear_wins: assert property (
      clear_term |-> q_ff == '0)
      else $error("clear term true but a flip-flop is high");

   chk_erase_opens: assert property (
      wr_erase |=> (cell_mem[`SOP_PT_PRESET] == '0) && (cell_mem[`SOP_PT_CLEAR] == '0)
                   && (mcfg_flat == '0))
      else $error("erase left a crossing connected");

   chk_empty_true: assert property (
      erase_seen_ff |-> (pt == {`SOP_N_TERM{1'b1}}) && (cell_io_pins_oe == '1))
      else $error("erased terms are not all true");

   chk_read_only_next: assert property (
      !$past(cfg_rd) |-> cfg_rdata == '0)
      else $error("read data present without a read");

   chk_read_row: assert property (
      rd_row && !wr_erase ##1 !wr_erase |-> cfg_rdata == cell_mem[$past(cfg_addr)])
      else $error("read data do not match the stored row");

   chk_fb_source: assert property (
      (fb & ~fbsel) == (~q_ff & ~fbsel) && (fb & fbsel) == (cell_io_pins_in & fbsel))
      else $error("feedback taken from the wrong source");

   chk_reg_polarity: assert property (
      ##1 (q_ff == $past(nxt_q)) && !clear_term |->
         ((cell_io_pins_out ^ ~pol) & ~fbsel) == ($past(nxt_q) & ~fbsel))
      else $error("registered pin value does not follow flip-flop and polarity");

   // the flip-flops leave reset low, so registered inverted pins come up high
   chk_reset_state: assert property (
      $past(srst) |-> q_ff == '0)
      else $error("flip-flop not low after reset");

   // after an erase every cell is registered and inverted with its flip-flop cleared
   chk_erase_pins: assert property (
      erase_seen_ff |-> cell_io_pins_out == '1)
      else $error("pins not high after erase");

   // a combinational cell shows its sum through its own polarity bit only
   chk_comb_path: assert property (
      ((cell_io_pins_out ^ ~pol) & fbsel) == (sum & fbsel))
      else $error("combinational pin value does not follow the sum");

   // note: the clock line enters the array, so a term that uses it toggles
   // with the clock itself; such terms are only meaningful on combinational
   // cells, and a clear term built from it would clear on every high phase

endmodule : sop_logic_array

// [verification/sop_board_model.sv]
// board logic model: resolves each cell pin from device and board drivers
`timescale 1ns/1ps
module sop_board_model (
   // clock
   input  wire logic       clk,
   // device side of the pins
   input  wire logic [9:0] dev_out,
   input  wire logic [9:0] dev_oe,
   // board side of the pins
   input  wire logic [9:0] brd_val,
   input  wire logic [9:0] brd_en,
   // level seen on each wire
   output logic      [9:0] pin_lvl
);
   logic [9:0] float_ff = 10'h155;
   // no pull on the wires: an undriven pin wanders every cycle
   always_ff @(posedge clk) begin
      float_ff <= ~float_ff;
   end
   // device wins when enabled, else the board, else the floating level
   assign pin_lvl = (dev_oe & dev_out) | (~dev_oe & brd_en & brd_val)
                  | (~dev_oe & ~brd_en & float_ff);
endmodule : sop_board_model

// [verification/sop_logic_array_tb.sv]
// self-checking bench for the sum-of-products logic array
`timescale 1ns/1ps
`include "sop_defines.svh"
module sop_logic_array_tb;
   localparam logic [43:0] T_OFF = 44'h000_0000_000c;
   logic        clk;
   logic        srst = 1'h1;
   logic        cfg_wr = 1'h0;
   logic        cfg_rd = 1'h0;
   logic [10:0] dedicated_inputs = 11'h000;
   logic [7:0]  cfg_addr = 8'h00;
   logic [43:0] cfg_wdata = 44'h0;
   logic [43:0] cfg_rdata;
   logic [9:0]  pins_in, pins_out, pins_oe;
   logic [9:0]  brd_val = 10'h000;
   logic [9:0]  brd_en = 10'h000;
   int          miscompares = 0;
   int          n_compared = 0;
   int          cyc = 0;
   int          base;

   sop_logic_array u_dut (.clk(clk), .srst(srst), .dedicated_inputs(dedicated_inputs),
      .cell_io_pins_in(pins_in), .cell_io_pins_out(pins_out), .cell_io_pins_oe(pins_oe),
      .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
      .cfg_rdata(cfg_rdata));
   sop_board_model u_brd (.clk(clk), .dev_out(pins_out), .dev_oe(pins_oe),
      .brd_val(brd_val), .brd_en(brd_en), .pin_lvl(pins_in));

   task chk(input string nm, input logic [43:0] e, input logic [43:0] g);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task wr(input int a, input logic [43:0] d);
      @(posedge clk);
      cfg_wr <= 1'h1;
      cfg_addr <= 8'(a);
      cfg_wdata <= d;
      @(posedge clk);
      cfg_wr <= 1'h0;
      #1;
   endtask : wr
   task rd(input int a, input logic [43:0] e);
      @(posedge clk);
      cfg_rd <= 1'h1;
      cfg_addr <= 8'(a);
      @(posedge clk);
      cfg_rd <= 1'h0;
      #1;
      chk("cfg_rdata", e, cfg_rdata);
      @(posedge clk);
      #1;
      chk("cfg_rdata", 44'h0, cfg_rdata);
   endtask : rd
   task tick;
      @(posedge clk);
      #1;
   endtask : tick
   task end_of_test;
      if (miscompares == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_of_test

   // clock and hang guard
   initial begin
      clk = 1'h0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         miscompares++;
         end_of_test;
      end
   end

   // main sequence: erase, program, then exercise each cell feature
   initial begin
      repeat (5) @(posedge clk);
      srst <= 1'h0;
      wr(`SOP_ADDR_ERASE, 44'h0);
      chk("pins_out", 44'h3ff, 44'(pins_out));
      chk("pins_oe", 44'h3ff, 44'(pins_oe));
      rd(5, 44'h0);
      wr(`SOP_PT_CLEAR, T_OFF);
      wr(`SOP_PT_PRESET, T_OFF);
      for (int r = `SOP_PT_SUM0; r < `SOP_PT_OE0; r++) wr(r, T_OFF);
      wr(`SOP_ADDR_MCFG, 44'h5_5555);
      rd(`SOP_ADDR_MCFG, 44'h5_5555);
      tick;
      chk("pins_out", 44'h0, 44'(pins_out));
      // one true term at the end of each group drives only its own cell
      base = `SOP_PT_SUM0;
      for (int c = 0; c < 10; c++) begin
         base += (c < 5) ? 8 + 2 * c : 26 - 2 * c;
         wr(base - 1, 44'h0);
         tick;
         chk("pins_out", 44'(10'h001 << c), 44'(pins_out));
         wr(base - 1, T_OFF);
      end
      // preset on the edge, clear at once and over the preset
      wr(`SOP_PT_PRESET, 44'h0);
      tick;
      chk("pins_out", 44'h3ff, 44'(pins_out));
      wr(`SOP_PT_CLEAR, 44'h0);
      chk("pins_out", 44'h0, 44'(pins_out));
      wr(`SOP_PT_CLEAR, T_OFF);
      tick;
      chk("pins_out", 44'h3ff, 44'(pins_out));
      wr(`SOP_PT_PRESET, T_OFF);
      // cell 0 and 9 combinational, cell 9 driver off, cell 0 reads input 1
      wr(`SOP_ADDR_MCFG, 44'hd_5557);
      wr(`SOP_PT_OE0 + 9, T_OFF);
      wr(`SOP_PT_SUM0, 44'h000_0000_0004);
      chk("pins_oe", 44'h1ff, 44'(pins_oe));
      for (int v = 0; v < 2; v++) begin
         @(posedge clk);
         dedicated_inputs <= 11'(v);
         #1;
         chk("pins_out", 44'(v), 44'(pins_out[0]));
      end
      wr(`SOP_ADDR_MCFG, 44'hd_5556);
      chk("pins_out", 44'h0, 44'(pins_out[0]));
      // cell 0 reads the pin of cell 9, driven by the board
      wr(`SOP_ADDR_MCFG, 44'hd_5557);
      wr(`SOP_PT_SUM0, 44'h400_0000_0000);
      brd_en <= 10'h200;
      for (int v = 0; v < 2; v++) begin
         @(posedge clk);
         brd_val <= 10'(v << 9);
         #1;
         chk("pins_out", 44'(v), 44'(pins_out[0]));
      end
      // cell 0 reads the registered feedback of cell 1
      wr(`SOP_PT_SUM0, 44'h000_0400_0000);
      tick;
      chk("pins_out", 44'h1, 44'(pins_out[0]));
      wr(`SOP_PT_PRESET, 44'h0);
      tick;
      chk("pins_out", 44'h0, 44'(pins_out[0]));
      rd(`SOP_PT_SUM0, 44'h000_0400_0000);
      rd(`SOP_ADDR_ERASE, 44'h0);
      rd(8'h86, 44'h0);
      end_of_test;
   end
endmodule : sop_logic_array_tb
